// ===== hdl/cdb_pkg.sv
// Package with register map, field positions, command codes and timing for the done block.
package cdb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the APB bus)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h00C;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h010;
  localparam logic [11:0] BOOT_BASE = 12'h400;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_OE_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam int CMD_BUSY_BIT = 8;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BOOT_BIT = 1;
  localparam int STAT_RP_BIT = 2;
  localparam int IRQ_CMD_BIT = 0;
  localparam int IRQ_BOOT_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_LOAD = 3'h0;
  localparam logic [2:0] CMD_PROGRAM = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h2;
  localparam logic [2:0] CMD_CACHE_RD = 3'h3;
  localparam logic [2:0] CMD_BURST_RD = 3'h4;

  // ----------------------------------------------------------------
  // Boot buffer size and copy timing
  // ----------------------------------------------------------------
  localparam int BOOT_AW = 8;
  localparam int BOOT_WORDS = 256;
  localparam int CLK_MHZ = 100;
  localparam int BOOT_DELAY_US = 400;
  localparam int BOOT_DELAY_CYC = BOOT_DELAY_US * CLK_MHZ;

endpackage

// ===== hdl/cdb_boot.sv
// Boot copier: waits after reset, then fills the boot buffer from the flash array.
`timescale 1ns/1ps
module cdb_boot
  import cdb_pkg::*;
#(
  parameter int DELAY_CYC = BOOT_DELAY_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flash array word source
  output logic flash_req,
  output logic [BOOT_AW-1:0] flash_addr,
  input wire logic [31:0] flash_rdata,
  input wire logic flash_ack,
  // Buffer read port and status
  input wire logic [BOOT_AW-1:0] rd_addr,
  output logic [31:0] rd_data,
  output logic boot_done
);

  typedef enum logic [1:0] {ST_WAIT, ST_COPY, ST_DONE} cdb_boot_st_t;

  cdb_boot_st_t state_reg;
  logic [31:0] delay_reg;
  logic [BOOT_AW-1:0] addr_reg;
  logic req_reg;
  logic [31:0] mem [BOOT_WORDS];

  // ----------------------------------------------------------------
  // Copy sequencer
  // ----------------------------------------------------------------
  // The delay gives supply time to settle before the array is trusted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_WAIT;
      delay_reg <= 32'h0000_0000;
      addr_reg <= 8'h00;
      req_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_WAIT: begin
          if (delay_reg == 32'(DELAY_CYC - 1)) begin // R12
            state_reg <= ST_COPY;
            req_reg <= 1'b1;
          end else begin
            delay_reg <= delay_reg + 32'h0000_0001;
          end
        end
        ST_COPY: begin
          if (flash_ack) begin
            addr_reg <= addr_reg + 8'h01;
            if (addr_reg == 8'(BOOT_WORDS - 1)) begin // R10
              state_reg <= ST_DONE;
              req_reg <= 1'b0;
            end
          end
        end
        ST_DONE: begin
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_WAIT;
        end
      endcase
    end
  end

  // Buffer fill; no reset so the array maps onto plain memory.
  always_ff @(posedge pclk) begin
    if (state_reg == ST_COPY && flash_ack) begin
      mem[addr_reg] <= flash_rdata; // R10
    end
  end

  assign flash_req = req_reg;
  assign flash_addr = addr_reg;
  assign boot_done = (state_reg == ST_DONE);
  assign rd_data = mem[rd_addr];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_copy_start;
    @(posedge pclk) disable iff (!presetn)
      $rose(flash_req) |-> $past(delay_reg) == 32'(DELAY_CYC - 1);
  endproperty
  a_copy_start: assert property (p_copy_start) else $error("copy began early"); // R12

  property p_copy_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(boot_done) |-> addr_reg == 8'h00 && $past(addr_reg) == 8'hFF;
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy length wrong"); // R10

endmodule

// ===== hdl/cdb_done.sv
// Command completion signal, its status and interrupt registers, and the boot copy wrapper.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps

// Functional notes
// R1: Done output marks load, program, erase completion.
// R2: Cache and burst reads complete on buffer transfer.
// R3: Idle done output rests high at default polarity.
// R4: Normal mode: host clears done bit first; the code clears it on every command issue, CTRL_AUTO_BIT unused.
// R5: Auto mode: command issue clears done bit.
// R6: Completion sets done bit, output returns high.
// R7: Host may watch done output rising edge.
// R8: Output enable zero floats the done pin.
// R9: Async host ties enable lines, grounds clock.
// R10: Power-on copies first kilobyte to boot buffer.
// R11: Host loads later boot code via data buffer.
// R12: Boot copy starts 400 us after reset.
// R13: Done rises after copy and reset pin rise.
// R14: Output enable and polarity reset to one.
// R15: Done output stays low throughout an operation.
// R16: Done bit always matches output after polarity.
module cdb_done
  import cdb_pkg::*;
#(
  parameter int DELAY_CYC = BOOT_DELAY_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic reset_pin_n,
  output logic done_pin_o,
  output logic done_pin_oe_n,
  output logic irq,
  // Flash core command port
  output logic core_start,
  output logic [2:0] core_cmd,
  input wire logic core_done,
  input wire logic core_xfer_done,
  // Flash array word source for the boot copy
  output logic flash_req,
  output logic [BOOT_AW-1:0] flash_addr,
  input wire logic [31:0] flash_rdata,
  input wire logic flash_ack
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_boot(input logic [11:0] a);
    is_boot = (a[11:10] == BOOT_BASE[11:10]);
  endfunction

  function automatic logic is_xfer_cmd(input logic [2:0] c);
    is_xfer_cmd = (c == CMD_CACHE_RD) || (c == CMD_BURST_RD);
  endfunction

  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  logic [2:0] cmd_reg;
  logic busy_reg;
  logic int_reg;
  logic int_next;
  logic init_reg;
  logic rp_s1_reg;
  logic rp_s2_reg;
  logic rp_s3_reg;
  logic rp_seen_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic done_pin_reg;
  logic oe_n_reg;
  logic irq_reg;
  logic core_start_reg;
  logic [2:0] core_cmd_reg;
  logic boot_done;
  logic [31:0] boot_rdata;
  logic setup;
  logic wr;
  logic cmd_go;
  logic complete;
  logic init_set;

  // ----------------------------------------------------------------
  // Boot copier
  // ----------------------------------------------------------------
  cdb_boot #(
    .DELAY_CYC(DELAY_CYC)
  ) u_boot (
    .pclk(pclk),
    .presetn(presetn),
    .flash_req(flash_req),
    .flash_addr(flash_addr),
    .flash_rdata(flash_rdata),
    .flash_ack(flash_ack),
    .rd_addr(paddr[9:2]),
    .rd_data(boot_rdata),
    .boot_done(boot_done)
  );

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  // One wait-free answer: data is captured in setup, pready rises in access.
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  // Commands are dropped while busy or before the power-on sequence ends.
  assign cmd_go = wr & (paddr == CMD_OFS) & ~busy_reg & init_reg;
  assign complete = busy_reg & (is_xfer_cmd(cmd_reg) ? core_xfer_done : core_done); // R1 R2
  assign init_set = ~init_reg & boot_done & rp_seen_reg; // R13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~(is_boot(paddr) & ~pwrite) & ~(paddr == CTRL_OFS)
        & ~(paddr == CMD_OFS) & ~(paddr == STAT_OFS) & ~(paddr == IRQ_STAT_OFS)
        & ~(paddr == IRQ_MASK_OFS);
    end
  end

  // Read data mux; unmapped addresses read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= 32'h0000_0000;
      if (is_boot(paddr)) begin
        prdata_reg <= boot_rdata; // R10
      end else begin
        unique case (paddr)
          CTRL_OFS: prdata_reg[2:0] <= ctrl_reg;
          CMD_OFS: prdata_reg[CMD_BUSY_BIT:0] <= {busy_reg, 5'h00, cmd_reg};
          STAT_OFS: prdata_reg[STAT_RP_BIT:0] <= {rp_seen_reg, boot_done, int_reg}; // R16
          IRQ_STAT_OFS: prdata_reg[1:0] <= irq_stat_reg;
          IRQ_MASK_OFS: prdata_reg[1:0] <= irq_mask_reg;
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset pin synchroniser and edge capture
  // ----------------------------------------------------------------
  // The edge is taken from the second and third stages only.
  // Stages reset to the released level, so a pin already high gives no false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_s1_reg <= 1'b1;
      rp_s2_reg <= 1'b1;
      rp_s3_reg <= 1'b1;
      rp_seen_reg <= 1'b0;
    end else begin
      rp_s1_reg <= reset_pin_n;
      rp_s2_reg <= rp_s1_reg;
      rp_s3_reg <= rp_s2_reg;
      if (rp_s2_reg & ~rp_s3_reg) begin
        rp_seen_reg <= 1'b1; // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and done bit next values
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr && paddr == CTRL_OFS) begin
      ctrl_next = pwdata[2:0];
    end
  end

  // Host writes to the done bit are ignored mid-operation so the pin cannot
  // pulse; completion is applied last so a set beats any clear.
  always_comb begin
    int_next = int_reg;
    if (wr && paddr == STAT_OFS && !busy_reg && init_reg) begin
      int_next = pwdata[STAT_DONE_BIT]; // R4
    end
    if (cmd_go) begin
      int_next = 1'b0; // R5 R15
    end
    if (init_set || complete) begin
      int_next = 1'b1; // R6 R13
    end
  end

  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  // Every accepted command clears the done bit, so at polarity one the pin drops even without a host clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST; // R14
      int_reg <= 1'b0;
      init_reg <= 1'b0;
      busy_reg <= 1'b0;
      cmd_reg <= CMD_LOAD;
    end else begin
      ctrl_reg <= ctrl_next;
      int_reg <= int_next;
      if (init_set) begin
        init_reg <= 1'b1;
      end
      if (cmd_go) begin
        busy_reg <= 1'b1;
        cmd_reg <= pwdata[2:0];
      end else if (complete) begin
        busy_reg <= 1'b0; // R1
      end
    end
  end

  // The core gets a one-cycle start pulse and a held copy of the code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_start_reg <= 1'b0;
      core_cmd_reg <= CMD_LOAD;
    end else begin
      core_start_reg <= cmd_go;
      if (cmd_go) begin
        core_cmd_reg <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Done pin
  // ----------------------------------------------------------------
  // The pin follows the next done value so it tracks the status bit exactly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pin_reg <= 1'b0;
      oe_n_reg <= 1'b0;
    end else begin
      done_pin_reg <= ctrl_next[CTRL_POL_BIT] ? int_next : ~int_next; // R3 R16
      oe_n_reg <= ~ctrl_next[CTRL_OE_BIT]; // R8 R14
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    if (wr && paddr == IRQ_STAT_OFS) begin
      irq_stat_next = irq_stat_reg & ~pwdata[1:0];
    end
    if (wr && paddr == IRQ_MASK_OFS) begin
      irq_mask_next = pwdata[1:0];
    end
    if (complete) begin
      irq_stat_next[IRQ_CMD_BIT] = 1'b1;
    end
    if (init_set) begin
      irq_stat_next[IRQ_BOOT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= IRQ_MASK_RST;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= |(irq_stat_next & irq_mask_next);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign done_pin_o = done_pin_reg;
  assign done_pin_oe_n = oe_n_reg;
  assign irq = irq_reg;
  assign core_start = core_start_reg;
  assign core_cmd = core_cmd_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_issue;
    cmd_go ##1 busy_reg;
  endsequence

  sequence s_finish;
    complete ##1 (int_reg && !busy_reg);
  endsequence

  property p_done_cmd;
    s_finish |-> irq_stat_reg[IRQ_CMD_BIT];
  endproperty
  a_done_cmd: assert property (p_done_cmd) else $error("completion lost"); // R1

  property p_xfer_only;
    busy_reg && is_xfer_cmd(cmd_reg) && !core_xfer_done |=> busy_reg;
  endproperty
  a_xfer_only: assert property (p_xfer_only) else $error("read ended early"); // R2

  property p_idle_high;
    init_reg && !busy_reg && int_reg && ctrl_reg[CTRL_POL_BIT] |-> done_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle pin low"); // R3

  property p_auto_clear;
    s_issue |-> !int_reg && core_start;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("no clear on issue"); // R5

  property p_finish_pin;
    s_finish |-> done_pin_o == ctrl_reg[CTRL_POL_BIT];
  endproperty
  a_finish_pin: assert property (p_finish_pin) else $error("pin not back"); // R6

  property p_float;
    !ctrl_reg[CTRL_OE_BIT] |-> done_pin_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("pin driven while off"); // R8

  property p_init_cond;
    $rose(init_reg) |-> int_reg && boot_done && rp_seen_reg;
  endproperty
  a_init_cond: assert property (p_init_cond) else $error("early init done"); // R13

  property p_busy_low;
    busy_reg && $past(busy_reg) |-> $stable(done_pin_o) && !int_reg;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("pin moved mid-op"); // R15

  property p_match;
    done_pin_o == (ctrl_reg[CTRL_POL_BIT] ? int_reg : !int_reg);
  endproperty
  a_match: assert property (p_match) else $error("pin and bit differ"); // R16

endmodule

// ===== verification/cdb_flash_model.sv
// Stand-in for the flash core and array: answers commands and the boot copy word reads.
`timescale 1ns/1ps
module cdb_flash_model
  import cdb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command side
  input wire logic core_start,
  input wire logic [2:0] core_cmd,
  input wire logic [7:0] lat,
  output logic core_done,
  output logic core_xfer_done,
  // Boot copy side
  input wire logic flash_req,
  input wire logic [BOOT_AW-1:0] flash_addr,
  output logic [31:0] flash_rdata,
  output logic flash_ack
);
  logic run_reg;
  logic [7:0] cnt_reg;
  logic [2:0] cmd_reg;

  // -----------------------------------------------------------------
  // Command execution
  // -----------------------------------------------------------------
  // A command runs for lat + 1 cycles; cache and burst reads end on the transfer pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      cmd_reg <= 3'h0;
      core_done <= 1'b0;
      core_xfer_done <= 1'b0;
    end else begin
      core_done <= 1'b0;
      core_xfer_done <= 1'b0;
      if (core_start) begin
        run_reg <= 1'b1;
        cnt_reg <= lat;
        cmd_reg <= core_cmd;
      end else if (run_reg && cnt_reg == 8'h00) begin
        run_reg <= 1'b0;
        core_xfer_done <= (cmd_reg == CMD_CACHE_RD || cmd_reg == CMD_BURST_RD);
        core_done <= !(cmd_reg == CMD_CACHE_RD || cmd_reg == CMD_BURST_RD);
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // -----------------------------------------------------------------
  // Boot copy word source
  // -----------------------------------------------------------------
  // Every other cycle a word is offered; between offers the data turns over so stale data shows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ack <= 1'b0;
      flash_rdata <= 32'h0000_0000;
    end else if (flash_req && !flash_ack) begin
      flash_ack <= 1'b1;
      flash_rdata <= 32'hA5C3_0000 | 32'(flash_addr);
    end else begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule

// ===== verification/cdb_done_tb.sv
// Self-checking bench for the done block: APB tasks, boot, interrupt and command tests.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module cdb_done_tb
  import cdb_pkg::*;
;
  localparam int DLY = 20;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, reset_pin_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, flash_rdata, rd;
  logic done_pin_o, done_pin_oe_n, irq, core_start, core_done, core_xfer_done;
  logic flash_req, flash_ack, err, in_op, last_req;
  logic [2:0] core_cmd;
  logic [7:0] lat;
  logic [BOOT_AW-1:0] flash_addr;
  int error_cnt = 0;
  int comparisons = 0;
  int start_cnt = 0;
  int rel_cnt = 0;

  // -----------------------------------------------------------------
  // Clock, design and far side
  // -----------------------------------------------------------------
  always #5 pclk = ~pclk;

  cdb_done #(.DELAY_CYC(DLY)) u_cdb_done (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n), .done_pin_o(done_pin_o),
    .done_pin_oe_n(done_pin_oe_n), .irq(irq), .core_start(core_start), .core_cmd(core_cmd),
    .core_done(core_done), .core_xfer_done(core_xfer_done), .flash_req(flash_req),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_ack(flash_ack));

  cdb_flash_model u_cdb_flash_model (.pclk(pclk), .presetn(presetn), .core_start(core_start),
    .core_cmd(core_cmd), .lat(lat), .core_done(core_done), .core_xfer_done(core_xfer_done),
    .flash_req(flash_req), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .flash_ack(flash_ack));

  // -----------------------------------------------------------------
  // Monitors
  // -----------------------------------------------------------------
  // The pin must stay low from issue to completion; the copy must wait the full delay.
  always @(posedge pclk) begin
    if (core_start === 1'b1) begin
      start_cnt++;
      in_op = 1'b1;
    end else if (core_done === 1'b1 || core_xfer_done === 1'b1) begin
      in_op = 1'b0;
    end else if (in_op) begin
      `CHK("pin low in op", 1'b0, done_pin_o)
    end
    if (presetn !== 1'b1) rel_cnt = 0;
    else if (flash_req !== 1'b1) rel_cnt++;
    else if (last_req !== 1'b1) `CHK("copy start", DLY, rel_cnt)
    last_req = flash_req;
  end

  // -----------------------------------------------------------------
  // Bus and wait tasks
  // -----------------------------------------------------------------
  // One APB transfer; the request is held until pready is seen at an edge.
  // Select carries both chip enable and address valid, on the one bus clock.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) `CHK("apb answer", 1'b1, pready)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_pin;
    int n;
    n = 0;
    while (done_pin_o !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    `CHK("pin rise", 1'b1, done_pin_o)
  endtask

  task automatic wait_boot;
    int n;
    n = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0000_0000);
      n++;
    end while (rd[STAT_BOOT_BIT] !== 1'b1 && n < 400);
    `CHK("boot poll", 1'b1, rd[STAT_BOOT_BIT])
  endtask

  // A slow command: busy and a low pin meanwhile, a second command ignored, then completion.
  task automatic run_cmd(input logic [2:0] code);
    apb(1'b1, STAT_OFS, 32'h0000_0000);
    apb(1'b1, CMD_OFS, 32'(code));
    apb(1'b0, CMD_OFS, 32'h0000_0000);
    `CHK("busy", 32'h0000_0100 | 32'(code), rd)
    apb(1'b1, CMD_OFS, 32'(CMD_ERASE));
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    `CHK("done bit busy", 1'b0, rd[STAT_DONE_BIT])
    `CHK("core cmd", code, core_cmd)
    wait_pin;
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    `CHK("done set", 3'h7, rd[2:0])
    apb(1'b0, IRQ_STAT_OFS, 32'h0000_0000);
    `CHK("irq cmd", 1'b1, rd[IRQ_CMD_BIT])
    apb(1'b1, IRQ_STAT_OFS, 32'h0000_0001);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs about 14 us.
  initial begin
    #300us;
    error_cnt++;
    $display("Error watchdog expected end seen hang");
    test_done;
  end

  // -----------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    reset_pin_n = 1'b0;
    lat = 8'd30;
    in_op = 1'b0;
    last_req = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0003, rd)
    `CHK("oe reset", 1'b0, done_pin_oe_n)
    apb(1'b0, IRQ_MASK_OFS, 32'h0000_0000);
    `CHK("mask reset", 32'h0000_0000, rd)
    wait_boot;
    `CHK("copy only", 3'h2, rd[2:0])
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    `CHK("init done", 3'h7, rd[2:0])
    `CHK("idle pin", 1'b1, done_pin_o)
    apb(1'b1, IRQ_MASK_OFS, 32'h0000_0003);
    apb(1'b0, IRQ_STAT_OFS, 32'h0000_0000);
    `CHK("irq init", 2'h2, rd[1:0])
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, IRQ_STAT_OFS, 32'h0000_0002);
    apb(1'b0, IRQ_STAT_OFS, 32'h0000_0000);
    `CHK("irq clr", 2'h0, rd[1:0])
    `CHK("irq off", 1'b0, irq)
    for (int i = 0; i < BOOT_WORDS; i += 85) begin
      apb(1'b0, BOOT_BASE + 12'(4 * i), 32'h0000_0000);
      `CHK("boot word", 32'hA5C3_0000 | 32'(i), rd)
    end
    apb(1'b1, BOOT_BASE, 32'h0000_0000);
    `CHK("boot write err", 1'b1, err)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    for (int c = 0; c < 5; c++) run_cmd(3'(c));
    `CHK("starts", 5, start_cnt)
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    lat <= 8'd0;
    apb(1'b1, CMD_OFS, 32'(CMD_LOAD));
    @(posedge pclk);
    `CHK("auto clear", 1'b0, done_pin_o)
    wait_pin;
    `CHK("auto start", 6, start_cnt)
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    `CHK("pol low", 1'b0, done_pin_o)
    `CHK("oe off", 1'b1, done_pin_oe_n)
    presetn <= 1'b0;
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    reset_pin_n <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    `CHK("pin first", 3'h4, rd[2:0])
    `CHK("oe rearm", 1'b0, done_pin_oe_n)
    wait_boot;
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    `CHK("done at copy", 3'h7, rd[2:0])
    test_done;
  end
endmodule
